//--- rtl/sstr_regs.sv
// Self-test control, soft reset key and trim shadow register bank.
// Assumes the serial port front end gives one-cycle write/read strobes
// synchronous to clk, and that rst is the power-on reset.
`timescale 1ns/1ps
module sstr_regs
  import sstr_pkg::*;
#(
  parameter logic [39:0] TRIM_INIT = 40'h5544332211
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Sensor controls
  output logic self_test_enable,
  output logic self_test_force,
  output logic soft_reset_pulse,
  output logic trim_valid,
  output logic [39:0] trim_shadow
);
  import sstr_pkg::*;

  typedef struct packed {
    sstr_state_e st;
    logic [2:0] idx;
    logic [3:0] wait_cnt;
    logic [7:0] trim0;
    logic [7:0] trim1;
    logic [7:0] trim2;
    logic [7:0] trim3;
    logic [7:0] trim4;
    logic st_en;
    logic st_force;
    logic srst;
    logic valid;
    logic [7:0] rdata;
    logic rvalid;
  } sstr_state_s;

  sstr_state_s s_q;
  sstr_state_s s_d;
  logic [7:0] nvm_word;

  // Index presented to the store follows the load counter
  sstr_nvm_rom #(.TRIM_INIT(TRIM_INIT)) u_rom (
    .clk(clk),
    .idx(s_q.idx),
    .word(nvm_word)
  );

  // Read mux over the shadow array
  function automatic logic [7:0] trim_pick(input sstr_state_s s,
                                           input logic [2:0] i);
    unique case (i)
      3'h0: trim_pick = s.trim0;
      3'h1: trim_pick = s.trim1;
      3'h2: trim_pick = s.trim2;
      3'h3: trim_pick = s.trim3;
      default: trim_pick = s.trim4;
    endcase
  endfunction : trim_pick

  // Next-state logic for control, load sequencer and read port
  always_comb begin
    logic [7:0] off;
    off = reg_addr - SSTR_OFF_TRIM_FIRST;
    s_d = s_q;
    s_d.srst = 1'b0;
    s_d.rvalid = reg_rd;
    s_d.rdata = 8'h00;
    // Writes: only the two control bits are kept, the rest dropped
    if (reg_wr && reg_addr == SSTR_OFF_SELF_TEST) begin
      s_d.st_en = reg_wdata[SSTR_BIT_ST_ENABLE];
      s_d.st_force = reg_wdata[SSTR_BIT_ST_FORCE];
    end
    // Key write acts like power-on reset; wrong key does nothing
    if (reg_wr && reg_addr == SSTR_OFF_SOFT_RST &&
        reg_wdata == SSTR_RESET_KEY) begin
      s_d = '0;
      s_d.st = SSTR_LOAD;
      s_d.st_en = SSTR_SELF_TEST_RST[SSTR_BIT_ST_ENABLE];
      s_d.st_force = SSTR_SELF_TEST_RST[SSTR_BIT_ST_FORCE];
      s_d.srst = 1'b1;
      s_d.rvalid = reg_rd;
    end else begin
      // Same sequence for both resets, so no race can corrupt a word
      unique case (s_q.st)
        SSTR_IDLE: s_d.st = SSTR_LOAD;
        SSTR_LOAD: begin
          if (s_q.wait_cnt == SSTR_NVM_WAIT) begin
            unique case (s_q.idx)
              3'h0: s_d.trim0 = nvm_word;
              3'h1: s_d.trim1 = nvm_word;
              3'h2: s_d.trim2 = nvm_word;
              3'h3: s_d.trim3 = nvm_word;
              default: s_d.trim4 = nvm_word;
            endcase
            s_d.wait_cnt = 4'h0;
            if (s_q.idx == 3'(SSTR_TRIM_NUM - 1)) begin
              s_d.st = SSTR_DONE;
              s_d.valid = 1'b1;
            end else begin
              s_d.idx = s_q.idx + 3'h1;
            end
          end else begin
            s_d.wait_cnt = s_q.wait_cnt + 4'h1;
          end
        end
        SSTR_DONE: s_d.valid = 1'b1;
        default: s_d.st = SSTR_IDLE;
      endcase
      // Read answers one cycle later; reserved bits read zero
      if (reg_rd) begin
        if (reg_addr == SSTR_OFF_SELF_TEST) begin
          s_d.rdata = {6'h00, s_q.st_force, s_q.st_en};
        end else if (reg_addr >= SSTR_OFF_TRIM_FIRST &&
                     reg_addr <= SSTR_OFF_TRIM_LAST) begin
          s_d.rdata = trim_pick(s_q, off[2:0]);
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign self_test_enable = s_q.st_en;
  assign self_test_force = s_q.st_force;
  assign soft_reset_pulse = s_q.srst;
  assign trim_valid = s_q.valid;
  assign trim_shadow = {s_q.trim4, s_q.trim3, s_q.trim2, s_q.trim1,
                        s_q.trim0};
  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;

  // Self-test write lands next cycle
  a_st_write: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == SSTR_OFF_SELF_TEST |=>
    self_test_force == $past(reg_wdata[1]) &&
    self_test_enable == $past(reg_wdata[0]))
    else $error("self-test bits not written");
  // Self-test bits hold unless their register or the key is written
  a_st_hold: assert property (@(posedge clk) disable iff (rst)
    !(reg_wr && (reg_addr == SSTR_OFF_SELF_TEST ||
                 reg_addr == SSTR_OFF_SOFT_RST)) |=>
    $stable(self_test_force) && $stable(self_test_enable))
    else $error("self-test bits changed unasked");
  // Key write clears control and restarts load
  a_key_reset: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == SSTR_OFF_SOFT_RST && reg_wdata == SSTR_RESET_KEY
    |=> soft_reset_pulse && !trim_valid && !self_test_enable)
    else $error("key did not reset");
  // The reset pulse lasts a single cycle
  a_srst_pulse: assert property (@(posedge clk) disable iff (rst)
    soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  // Wrong key gives no reset pulse and leaves the enable bit alone
  a_bad_key: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == SSTR_OFF_SOFT_RST && reg_wdata != SSTR_RESET_KEY
    |=> !soft_reset_pulse && $stable(self_test_enable))
    else $error("wrong key had effect");
  // Load finishes within a bounded time after soft reset
  a_load_done: assert property (@(posedge clk) disable iff (rst)
    soft_reset_pulse |-> ##[1:20] trim_valid)
    else $error("trim load did not finish");
  // Power-on reset also reloads the shadows within a bounded time
  a_por_load: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> ##[1:20] trim_valid)
    else $error("power-on trim load did not finish");
  // Shadows are read-only once loaded; only a key write disturbs them
  a_trim_hold: assert property (@(posedge clk) disable iff (rst)
    trim_valid && !(reg_wr && reg_addr == SSTR_OFF_SOFT_RST) |=>
    $stable(trim_shadow) && trim_valid)
    else $error("shadow changed while loaded");
  // Loaded shadows equal the factory values
  a_load_ok: assert property (@(posedge clk) disable iff (rst)
    $rose(trim_valid) |-> trim_shadow == TRIM_INIT)
    else $error("trim shadow mismatch");
  // First and last shadow read back as held
  a_trim_first: assert property (@(posedge clk) disable iff (rst)
    reg_rd && !reg_wr && trim_valid && reg_addr == SSTR_OFF_TRIM_FIRST
    |=> reg_rvalid && reg_rdata == trim_shadow[7:0])
    else $error("first shadow readback wrong");
  a_trim_last: assert property (@(posedge clk) disable iff (rst)
    reg_rd && !reg_wr && trim_valid && reg_addr == SSTR_OFF_TRIM_LAST
    |=> reg_rvalid && reg_rdata == trim_shadow[39:32])
    else $error("last shadow readback wrong");
  // Self-test reads show reserved zeros
  a_st_read: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == SSTR_OFF_SELF_TEST && !reg_wr |=>
    reg_rvalid && reg_rdata[7:2] == 6'h00 &&
    reg_rdata[1:0] == {self_test_force, self_test_enable})
    else $error("self-test readback wrong");
  // Every read strobe is answered one cycle later
  a_rvalid_pulse: assert property (@(posedge clk) disable iff (rst)
    reg_rd |=> reg_rvalid)
    else $error("read not answered");
  // No answer and a quiet data bus when nothing was read
  a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read port not idle");
  // Unmapped and write-only addresses read as zero
  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr != SSTR_OFF_SELF_TEST &&
    !(reg_addr >= SSTR_OFF_TRIM_FIRST && reg_addr <= SSTR_OFF_TRIM_LAST)
    |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : sstr_regs

//--- rtl/sstr_pkg.sv
// Package for the self-test, soft reset and trim shadow register bank.
// Assumes a simple synchronous register port: address, write strobe, read.
package sstr_pkg;
  // Register offsets
  localparam logic [7:0] SSTR_OFF_SELF_TEST = 8'h2E;
  localparam logic [7:0] SSTR_OFF_SOFT_RST = 8'h2F;
  localparam logic [7:0] SSTR_OFF_TRIM_FIRST = 8'h50;
  localparam logic [7:0] SSTR_OFF_TRIM_LAST = 8'h54;
  // Field positions in the self-test register
  localparam int SSTR_BIT_ST_ENABLE = 0;
  localparam int SSTR_BIT_ST_FORCE = 1;
  // Reset values and key
  localparam logic [7:0] SSTR_SELF_TEST_RST = 8'h00;
  localparam logic [7:0] SSTR_RESET_KEY = 8'h52;
  localparam logic [7:0] SSTR_TRIM_RST = 8'h00;
  // Number of trim shadow registers
  localparam int SSTR_TRIM_NUM = 5;
  // Last wait count of each nonvolatile word fetch (three cycles per word)
  localparam logic [3:0] SSTR_NVM_WAIT = 4'h2;
  typedef enum logic [1:0] {SSTR_IDLE, SSTR_LOAD, SSTR_DONE} sstr_state_e;
endpackage : sstr_pkg

//--- rtl/sstr_nvm_rom.sv
// Factory trim nonvolatile store, modelled as a constant lookup.
// Assumes the word is valid one clock after the index is presented.
`timescale 1ns/1ps
module sstr_nvm_rom #(
  parameter logic [39:0] TRIM_INIT = 40'h5544332211
) (
  // Clock
  input wire logic clk,
  // Lookup
  input wire logic [2:0] idx,
  output logic [7:0] word
);
  // Registered read, as a real fuse array would answer
  always_ff @(posedge clk) begin
    word <= (idx < 3'h5) ? TRIM_INIT[idx*8 +: 8] : 8'h00;
  end
endmodule : sstr_nvm_rom

//--- test/sstr_host.sv
// Host model that owns the register port of the trim register bank.
// Assumes strobes are sampled on the rising edge of clk.
`timescale 1ns/1ps
module sstr_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Port idle at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Write strobe held through the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d; // Stale data must not look valid
  endtask : wr
  // Read; a missing valid turns the byte unknown so it never matches
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rvalid ? reg_rdata : 8'hXX;
  endtask : rd
  // Fetch all five trim shadows, first one in the low byte
  task automatic shadows(output logic [39:0] v);
    logic [7:0] b;
    for (int i = 0; i < 5; i++) begin
      rd(8'h50 + 8'(i), b);
      v[8*i +: 8] = b;
    end
  endtask : shadows
endmodule : sstr_host

//--- test/selftest_and_soft_reset_regs_tb.sv
// Self-checking bench for the self-test, soft reset and trim bank.
// Assumes the host model is the only driver of the register port.
`timescale 1ns/1ps
module selftest_and_soft_reset_regs_tb;
  import sstr_pkg::*;
  localparam logic [39:0] TRIM = 40'hA5C31E709B;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr, wdata, rdata, b, d;
  logic wr, rd, rvalid, st_en, st_frc, srst, tvalid;
  logic [39:0] shadow, saved, now_v;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  sstr_regs #(.TRIM_INIT(TRIM)) sstr_regs_inst (.clk(clk), .rst(rst),
    .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .self_test_enable(st_en),
    .self_test_force(st_frc), .soft_reset_pulse(srst),
    .trim_valid(tvalid), .trim_shadow(shadow));
  sstr_host sstr_host_inst (.clk(clk), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata),
    .reg_rvalid(rvalid));
  // 10 MHz clock
  always #50 clk = ~clk;
  // Cut a hung run short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] st_exp(input logic [7:0] v);
    return {6'h00, v[1:0]};
  endfunction : st_exp
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  // Bounded wait for the trim load, then the shadows must hold trim
  task automatic wait_trim();
    // Look just after each edge so the flag is settled, never racing it
    for (int k = 0; k < 40 && tvalid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk(tvalid, 1'b1);
    chk(shadow, TRIM);
  endtask : wait_trim
  // Main sequence
  initial begin
    void'($urandom(95118));
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    wait_trim();
    sstr_host_inst.shadows(saved);
    chk(saved, TRIM);
    sstr_host_inst.rd(SSTR_OFF_SELF_TEST, b);
    chk(b, SSTR_SELF_TEST_RST);
    sstr_host_inst.rd(8'h30, b);
    chk(b, 8'h00);
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      sstr_host_inst.wr(SSTR_OFF_SELF_TEST, d);
      chk({st_frc, st_en}, d[1:0]);
      sstr_host_inst.rd(SSTR_OFF_SELF_TEST, b);
      chk(b, st_exp(d));
      sstr_host_inst.wr(SSTR_OFF_SOFT_RST, (d == 8'h52) ? 8'h53 : d);
      chk({srst, st_frc, st_en}, {1'b0, d[1:0]});
      sstr_host_inst.wr(8'h50 + 8'(i % 5), ~d);
      chk(shadow, TRIM);
    end
    // Soft reset with both bits set, retried until shadows match
    for (int t = 0; t < 3; t++) begin
      sstr_host_inst.wr(SSTR_OFF_SELF_TEST, 8'h03);
      sstr_host_inst.wr(SSTR_OFF_SOFT_RST, SSTR_RESET_KEY);
      chk({srst, tvalid, st_frc, st_en}, 4'h8);
      wait_trim();
      sstr_host_inst.shadows(now_v);
      if (now_v === saved) break;
    end
    chk(now_v, saved);
    // Power-on reset in mid-run clears set bits and reloads trim
    sstr_host_inst.wr(SSTR_OFF_SELF_TEST, 8'h03);
    chk({st_frc, st_en}, 2'h3);
    @(posedge clk);
    #1 rst = 1'b1;
    #10;
    chk({srst, tvalid, st_frc, st_en}, 4'h0);
    chk(shadow, {SSTR_TRIM_NUM{SSTR_TRIM_RST}});
    @(posedge clk);
    #1 rst = 1'b0;
    wait_trim();
    sstr_host_inst.shadows(now_v);
    chk(now_v, saved);
    summarize();
  end
endmodule : selftest_and_soft_reset_regs_tb
